/* File: design/lmpsd_pkg.sv */
// lmpsd_pkg: register map, field positions, reset values and scan timing
// for the led matrix pwm, scan and diagnostic core.
// assumes a 20 MHz system clock; every cycle count below is derived from it.
package lmpsd_pkg;

  localparam int CLK_PERIOD_NS = 50;

  // register offsets
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_GLOBAL     = 8'h01;
  localparam logic [7:0] ADDR_SCALE_BASE = 8'h02;
  localparam logic [7:0] ADDR_DUTY_BASE  = 8'h0E;
  localparam logic [7:0] ADDR_DUTY_LAST  = 8'h3D;
  localparam logic [7:0] ADDR_DETECT     = 8'h61;
  localparam logic [7:0] ADDR_OPEN_BASE  = 8'h62;
  localparam logic [7:0] ADDR_OPEN_LAST  = 8'h65;
  localparam logic [7:0] ADDR_SHORT_BASE = 8'h68;
  localparam logic [7:0] ADDR_SHORT_LAST = 8'h6B;
  localparam logic [7:0] ADDR_SPREAD     = 8'h6E;
  localparam logic [7:0] ADDR_RESET      = 8'h7F;
  localparam logic [7:0] RESET_CMD       = 8'hAE;

  // field positions
  localparam int CTRL_RES_BIT    = 6;
  localparam int CTRL_ROWSEL_LSB = 4;
  localparam int DET_QUARTER_BIT = 7;
  localparam int DET_FREQ_LSB    = 4;
  localparam int DET_SHORT_BIT   = 1;
  localparam int DET_OPEN_BIT    = 0;
  localparam int SPREAD_EN_BIT   = 4;
  localparam logic [7:0] SPREAD_MASK = 8'h10;
  localparam logic [7:0] DUTY_HI_MASK = 8'h0F;

  // reset values
  localparam logic [7:0] CTRL_RESET   = 8'h20;
  localparam logic [7:0] GLOBAL_RESET = 8'h00;
  localparam logic [7:0] SCALE_RESET  = 8'h00;
  localparam logic [7:0] DUTY_RESET   = 8'h00;
  localparam logic [7:0] DETECT_RESET = 8'h00;
  localparam logic [5:0] RESULT_RESET = 6'h00;
  localparam logic [7:0] SPREAD_RESET = 8'h00;
  localparam logic [1:0] ROWSEL_HALF  = 2'b10;

  // matrix shape
  localparam int NUM_CH     = 12;
  localparam int NUM_DOTS   = 24;
  localparam int NUM_RESULT = 4;
  localparam int LEVEL_W    = 16;

  // duty resolution
  localparam logic [15:0] RES12_STEPS = 16'h1000;
  localparam logic [15:0] RES8_STEPS  = 16'h0100;

  // scan timing
  localparam int T_SCAN12_NS    = 235000;
  localparam int T_SCAN8_NS     = 15400;
  localparam int T_BLANK_NS     = 290;
  localparam int T_CHDLY_NS     = 120;
  localparam int SCAN12_CYCLES  = T_SCAN12_NS / CLK_PERIOD_NS;
  localparam int SCAN8_CYCLES   = T_SCAN8_NS / CLK_PERIOD_NS;
  localparam int BLANK_CYCLES   = (T_BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CHDLY_CYCLES   = (T_CHDLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WIN_OFFSET     = BLANK_CYCLES + CHDLY_CYCLES;

  // spread spectrum: span in tenths of a percent, sweep period
  localparam int SS_SPAN_PERMIL = 56;
  localparam int SS_CYCLE_NS    = 2099000;
  localparam int SS_CYCLE_CYCLES = SS_CYCLE_NS / CLK_PERIOD_NS;

  typedef enum {
    DET_IDLE,
    DET_ROW0,
    DET_ROW1
  } lmpsd_det_state_t;

endpackage

/* File: design/lmpsd_channel.sv */
// lmpsd_channel: one current sink; duty compare and peak level code.
// assumes step and window come from the shared scan engine, same clock.
`timescale 1ns/100ps
module lmpsd_channel
  import lmpsd_pkg::*;
(
  input  wire logic               i_clk_sys,
  input  wire logic               i_reset_n,
  input  wire logic               i_load,
  input  wire logic               i_window,
  input  wire logic               i_res12,
  input  wire logic [7:0]         i_duty_lo,
  input  wire logic [7:0]         i_duty_hi,
  input  wire logic [12:0]        i_step,
  input  wire logic [7:0]         i_global,
  input  wire logic [7:0]         i_scale,
  input  wire logic               i_quarter,
  output logic                    o_sink_on,
  output logic [LEVEL_W-1:0]      o_level
);

  logic [12:0] duty_hold;

  wire [12:0] next_duty = i_res12 ? {1'b0, i_duty_hi[3:0], i_duty_lo}
                                  : {5'h00, i_duty_lo};
  wire [LEVEL_W-1:0] full_level = i_global * i_scale;
  wire [LEVEL_W-1:0] next_level = i_quarter ? {2'b00, full_level[LEVEL_W-1:2]}
                                            : full_level;

  // duty is taken once per window so a mid-period write cannot glitch
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      duty_hold <= 13'h0000;
      o_sink_on <= 1'b0;
      o_level   <= 16'h0000;
    end else begin
      if (i_load) begin
        duty_hold <= next_duty; // see RL19
      end
      o_sink_on <= i_window && (i_step < duty_hold); // see RL14 see RL15
      o_level   <= next_level; // see RL11 see RL12
    end
  end

endmodule // lmpsd_channel

/* File: design/lmpsd_core.sv */
// lmpsd_core: register file, row scan, pwm timing, spread spectrum and
// one-shot open/short detection for a 12 channel by 2 row led matrix.
// assumes a host register port on the system clock and analog fault
// comparators whose flags arrive asynchronously on pins.
//
// Contract
// RL1: setting open trigger runs one open pass, results land in 62h-65h.
// RL2: setting short trigger runs one short pass, results land in 68h-6Bh.
// RL3: result registers read-only, six flags low, top two bits zero, reset zero.
// RL4: host sets global level 0x0F, de-ghost off, duty above 6% first.
// RL5: spread spectrum dithers switching frequency +-5.6% over a 2099us sweep.
// RL6: spread spectrum enable is bit four; other bits unused, zero.
// RL7: writing 0xAE to 7Fh returns every register to default.
// RL8: power-up loads defaults so the display starts blank.
// RL9: rows switched one after another, active high, with blanking between.
// RL10: default scan 235us or 15.4us, with 0.29us blank, 0.12us delay.
// RL11: peak current follows global code times per-channel code, N/256 each.
// RL12: low-current bit cuts every peak current to one quarter.
// RL13: host sets low-current bit below 8mA peak, clears it above.
// RL14: default duty is 12 bits from high nibble and low byte.
// RL15: resolution bit six set gives single byte duty, 256 steps.
// RL16: duty bytes at 0Eh-3Dh; low byte 4 gives fourth duty step.
// RL17: after reset, 12-bit duty and 4kHz frequency.
// RL18: frequency field selects 500Hz to 64kHz.
// RL19: duty writes accepted any time, applied from the next period.
// RL20: separate open and short flag for every led position.
// RL21: switch duty field sets row on fraction, default one half.
// RL22: results held until the next pass of same type; reads harmless.
// RL23: any other byte written to 7Fh changes nothing.
`timescale 1ns/100ps
module lmpsd_core
  import lmpsd_pkg::*;
#(
  parameter int P_SCAN12_CYCLES   = SCAN12_CYCLES,
  parameter int P_SS_CYCLE_CYCLES = SS_CYCLE_CYCLES
) (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_reset_n,
  input  wire logic                      i_reg_wr,
  input  wire logic                      i_reg_rd,
  input  wire logic [7:0]                i_reg_addr,
  input  wire logic [7:0]                i_reg_wdata,
  input  wire logic [NUM_CH-1:0]         i_open_sense,
  input  wire logic [NUM_CH-1:0]         i_short_sense,
  output logic      [7:0]                o_reg_rdata,
  output logic      [1:0]                o_row_scan_switch,
  output logic      [NUM_CH-1:0]         o_current_sink_channel,
  output logic      [NUM_CH*LEVEL_W-1:0] o_sink_level
);

  localparam int SS_STEP_CYCLES = P_SS_CYCLE_CYCLES / (4 * SS_SPAN_PERMIL);

  logic [7:0]  ctrl;
  logic [7:0]  global_current_level;
  logic [7:0]  detect;
  logic [7:0]  spread;
  logic [7:0]  channel_current_scale [NUM_CH];
  logic [7:0]  duty_mem [2*NUM_DOTS];
  logic [5:0]  open_res [NUM_RESULT];
  logic [5:0]  short_res [NUM_RESULT];

  // register decode
  wire soft_clr   = i_reg_wr && (i_reg_addr == ADDR_RESET)
                    && (i_reg_wdata == RESET_CMD); // see RL7 see RL23
  wire wr_ctrl    = i_reg_wr && (i_reg_addr == ADDR_CTRL);
  wire wr_global  = i_reg_wr && (i_reg_addr == ADDR_GLOBAL);
  wire wr_detect  = i_reg_wr && (i_reg_addr == ADDR_DETECT);
  wire wr_spread  = i_reg_wr && (i_reg_addr == ADDR_SPREAD);
  wire in_scale   = (i_reg_addr >= ADDR_SCALE_BASE) && (i_reg_addr < ADDR_DUTY_BASE);
  wire in_duty    = (i_reg_addr >= ADDR_DUTY_BASE) && (i_reg_addr <= ADDR_DUTY_LAST);
  wire in_open    = (i_reg_addr >= ADDR_OPEN_BASE) && (i_reg_addr <= ADDR_OPEN_LAST);
  wire in_short   = (i_reg_addr >= ADDR_SHORT_BASE) && (i_reg_addr <= ADDR_SHORT_LAST);
  wire [7:0] scale_off = i_reg_addr - ADDR_SCALE_BASE;
  wire [7:0] duty_off  = i_reg_addr - ADDR_DUTY_BASE;
  wire [7:0] open_off  = i_reg_addr - ADDR_OPEN_BASE;
  wire [7:0] short_off = i_reg_addr - ADDR_SHORT_BASE;
  // upper nibble of the high duty byte is reserved and kept at zero
  wire [7:0] duty_wdata = duty_off[0] ? (i_reg_wdata & DUTY_HI_MASK) : i_reg_wdata;

  // mode decode
  wire       res12       = !ctrl[CTRL_RES_BIT]; // see RL14 see RL15 see RL17
  wire [1:0] switch_duty_select = ctrl[CTRL_ROWSEL_LSB +: 2];
  wire       two_rows    = switch_duty_select[1]; // see RL21
  wire [2:0] pwm_frequency_select = detect[DET_FREQ_LSB +: 3];
  wire       low_current_quarter  = detect[DET_QUARTER_BIT];
  wire       spread_spectrum_enable = spread[SPREAD_EN_BIT]; // see RL6

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ctrl                 <= CTRL_RESET; // see RL8
      global_current_level <= GLOBAL_RESET;
      spread               <= SPREAD_RESET;
    end else if (soft_clr) begin
      ctrl                 <= CTRL_RESET;
      global_current_level <= GLOBAL_RESET;
      spread               <= SPREAD_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= i_reg_wdata;
      end
      if (wr_global) begin
        global_current_level <= i_reg_wdata;
      end
      if (wr_spread) begin
        spread <= i_reg_wdata & SPREAD_MASK;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < NUM_CH; i++) begin
        channel_current_scale[i] <= SCALE_RESET;
      end
      for (int i = 0; i < 2*NUM_DOTS; i++) begin
        duty_mem[i] <= DUTY_RESET;
      end
    end else if (soft_clr) begin
      for (int i = 0; i < NUM_CH; i++) begin
        channel_current_scale[i] <= SCALE_RESET;
      end
      for (int i = 0; i < 2*NUM_DOTS; i++) begin
        duty_mem[i] <= DUTY_RESET;
      end
    end else if (i_reg_wr) begin
      if (in_scale) begin
        channel_current_scale[scale_off[3:0]] <= i_reg_wdata;
      end
      if (in_duty) begin
        duty_mem[duty_off[5:0]] <= duty_wdata; // see RL16 see RL19
      end
    end
  end

  // detection state
  lmpsd_det_state_t det_state;
  logic             pass_open;
  logic             pass_short;
  logic [NUM_CH-1:0] open_meta;
  logic [NUM_CH-1:0] open_sync;
  logic [NUM_CH-1:0] short_meta;
  logic [NUM_CH-1:0] short_sync;

  // scan engine state
  logic        row;
  logic [15:0] phase;
  logic [15:0] period;
  logic [15:0] acc;
  logic [12:0] step;
  logic signed [7:0] tri_pos;
  logic        tri_up;
  logic [15:0] ss_div;

  wire win_end   = (phase == period - 16'h0001);
  wire win_start = (phase == 16'(WIN_OFFSET - 1));
  wire in_window = (phase >= 16'(WIN_OFFSET));
  wire blank     = (phase < 16'(BLANK_CYCLES));

  wire det_done  = ((det_state == DET_ROW0) && win_end && !row && !two_rows)
                   || ((det_state == DET_ROW1) && win_end && row);

  // host write wins over the end-of-pass clear of the trigger bits
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      detect <= DETECT_RESET;
    end else if (soft_clr) begin
      detect <= DETECT_RESET;
    end else if (wr_detect) begin
      detect <= i_reg_wdata;
    end else if (det_done) begin
      detect[DET_OPEN_BIT]  <= 1'b0;
      detect[DET_SHORT_BIT] <= 1'b0;
    end
  end

  // fault comparators are asynchronous to the core clock
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      open_meta  <= 12'h000;
      open_sync  <= 12'h000;
      short_meta <= 12'h000;
      short_sync <= 12'h000;
    end else begin
      open_meta  <= i_open_sense;
      open_sync  <= open_meta;
      short_meta <= i_short_sense;
      short_sync <= short_meta;
    end
  end

  // one pass samples each row at the end of its sink window
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      det_state  <= DET_IDLE;
      pass_open  <= 1'b0;
      pass_short <= 1'b0;
    end else if (soft_clr) begin
      det_state  <= DET_IDLE;
      pass_open  <= 1'b0;
      pass_short <= 1'b0;
    end else begin
      case (det_state)
        DET_IDLE: begin
          if (detect[DET_OPEN_BIT] || detect[DET_SHORT_BIT]) begin
            pass_open  <= detect[DET_OPEN_BIT]; // see RL1
            pass_short <= detect[DET_SHORT_BIT]; // see RL2
            det_state  <= DET_ROW0;
          end
        end
        DET_ROW0: begin
          if (win_end && !row) begin
            det_state <= two_rows ? DET_ROW1 : DET_IDLE;
          end
        end
        DET_ROW1: begin
          if (win_end && row) begin
            det_state <= DET_IDLE;
          end
        end
        default: begin
          det_state <= DET_IDLE;
        end
      endcase
    end
  end

  wire cap_row0 = (det_state == DET_ROW0) && win_end && !row;
  wire cap_row1 = (det_state == DET_ROW1) && win_end && row;
  wire cap_any  = cap_row0 || cap_row1;
  wire [1:0] cap_base = cap_row1 ? 2'd2 : 2'd0;

  // results are left alone until a pass of the same type rewrites them
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < NUM_RESULT; i++) begin
        open_res[i]  <= RESULT_RESET; // see RL3
        short_res[i] <= RESULT_RESET;
      end
    end else if (soft_clr) begin
      for (int i = 0; i < NUM_RESULT; i++) begin
        open_res[i]  <= RESULT_RESET;
        short_res[i] <= RESULT_RESET;
      end
    end else if (cap_any) begin
      if (pass_open) begin
        open_res[cap_base]         <= open_sync[5:0]; // see RL1 see RL20 see RL22
        open_res[cap_base + 2'd1]  <= open_sync[11:6];
      end
      if (pass_short) begin
        short_res[cap_base]        <= short_sync[5:0]; // see RL2 see RL20 see RL22
        short_res[cap_base + 2'd1] <= short_sync[11:6];
      end
    end
  end

  // period: 12-bit mode stays at 4 kHz for frequency codes 0 to 4
  wire [2:0]  scan_shift  = res12 ? (pwm_frequency_select[2] ? {1'b0, pwm_frequency_select[1:0]}
                                                              : 3'd0)
                                  : pwm_frequency_select; // see RL18
  wire [15:0] base_scan   = res12 ? 16'(P_SCAN12_CYCLES) : 16'(SCAN8_CYCLES); // see RL10
  wire [15:0] base_period = base_scan << scan_shift;
  wire signed [24:0] dither_prod  = $signed({9'h000, base_period}) * tri_pos;
  wire signed [24:0] dither_delta = dither_prod / 25'sd1000;
  wire [15:0] next_period = base_period + dither_delta[15:0]; // see RL5
  wire [15:0] on_len      = period - 16'(WIN_OFFSET);
  wire [15:0] res_steps   = res12 ? RES12_STEPS : RES8_STEPS;
  wire [15:0] acc_sum     = acc + res_steps;

  // triangle sweep of the period offset, in tenths of a percent
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      tri_pos <= 8'sh00;
      tri_up  <= 1'b1;
      ss_div  <= 16'h0000;
    end else if (!spread_spectrum_enable) begin
      tri_pos <= 8'sh00;
      tri_up  <= 1'b1;
      ss_div  <= 16'h0000;
    end else if (ss_div == 16'(SS_STEP_CYCLES - 1)) begin
      ss_div <= 16'h0000;
      if (tri_up) begin
        if (tri_pos == 8'(SS_SPAN_PERMIL)) begin
          tri_up  <= 1'b0;
          tri_pos <= tri_pos - 8'sh01; // see RL5
        end else begin
          tri_pos <= tri_pos + 8'sh01;
        end
      end else begin
        if (tri_pos == -8'(SS_SPAN_PERMIL)) begin
          tri_up  <= 1'b1;
          tri_pos <= tri_pos + 8'sh01;
        end else begin
          tri_pos <= tri_pos - 8'sh01;
        end
      end
    end else begin
      ss_div <= ss_div + 16'h0001;
    end
  end

  // row phase: blank, switch on with sinks held, then the sink window
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      phase  <= 16'h0000;
      period <= 16'(P_SCAN12_CYCLES);
      row    <= 1'b0;
    end else if (win_end) begin
      phase  <= 16'h0000;
      period <= next_period;
      row    <= two_rows ? !row : 1'b0; // see RL9 see RL21
    end else begin
      phase  <= phase + 16'h0001;
    end
  end

  // spreads res steps evenly over the sink window
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      acc  <= 16'h0000;
      step <= 13'h0000;
    end else if (win_start) begin
      acc  <= 16'h0000;
      step <= 13'h0000;
    end else if (in_window && (acc_sum >= on_len)) begin
      acc  <= acc_sum - on_len;
      step <= step + 13'h0001; // see RL14 see RL15
    end else if (in_window) begin
      acc  <= acc_sum;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_row_scan_switch <= 2'b00;
    end else begin
      o_row_scan_switch[0] <= !row && !blank; // see RL9 see RL10
      o_row_scan_switch[1] <= row && !blank;
    end
  end

  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    wire [7:0] lo = row ? duty_mem[2*(ch+NUM_CH)]     : duty_mem[2*ch];
    wire [7:0] hi = row ? duty_mem[2*(ch+NUM_CH) + 1] : duty_mem[2*ch + 1];

    lmpsd_channel u_channel (
      .i_clk_sys (i_clk_sys),
      .i_reset_n (i_reset_n),
      .i_load    (win_start),
      .i_window  (in_window),
      .i_res12   (res12),
      .i_duty_lo (lo),
      .i_duty_hi (hi),
      .i_step    (step),
      .i_global  (global_current_level),
      .i_scale   (channel_current_scale[ch]),
      .i_quarter (low_current_quarter),
      .o_sink_on (o_current_sink_channel[ch]),
      .o_level   (o_sink_level[ch*LEVEL_W +: LEVEL_W])
    );
  end

  // read path; 7Fh is write-only and unmapped offsets read zero
  wire [7:0] rd_scale = in_scale ? channel_current_scale[scale_off[3:0]] : 8'h00;
  wire [7:0] rd_duty  = in_duty ? duty_mem[duty_off[5:0]] : 8'h00;
  wire [7:0] rd_open  = in_open ? {2'b00, open_res[open_off[1:0]]} : 8'h00; // see RL3
  wire [7:0] rd_short = in_short ? {2'b00, short_res[short_off[1:0]]} : 8'h00;
  wire [7:0] rd_value = (i_reg_addr == ADDR_CTRL)   ? ctrl :
                        (i_reg_addr == ADDR_GLOBAL) ? global_current_level :
                        (i_reg_addr == ADDR_DETECT) ? detect :
                        (i_reg_addr == ADDR_SPREAD) ? spread :
                        (rd_scale | rd_duty | rd_open | rd_short);

  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rd_value; // see RL22
    end
  end

endmodule // lmpsd_core

/* File: test/lmpsd_matrix.sv */
// lmpsd_matrix: led matrix stand-in showing fault flags of the lit row.
// assumes fault maps from the bench, dot d<12 is row0 channel d.
`timescale 1ns/100ps
module lmpsd_matrix
  import lmpsd_pkg::*;
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_reset_n,
  input  wire logic [1:0]        i_rows,
  input  wire logic [NUM_DOTS-1:0] i_open_map,
  input  wire logic [NUM_DOTS-1:0] i_short_map,
  output logic      [NUM_CH-1:0] o_open_sense,
  output logic      [NUM_CH-1:0] o_short_sense
);
  // comparators mean nothing with no row lit, so toggle rather than hold
  always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_open_sense  <= '0;
      o_short_sense <= '0;
    end else if (i_rows[0]) begin
      o_open_sense  <= i_open_map[NUM_CH-1:0];
      o_short_sense <= i_short_map[NUM_CH-1:0];
    end else if (i_rows[1]) begin
      o_open_sense  <= i_open_map[NUM_DOTS-1:NUM_CH];
      o_short_sense <= i_short_map[NUM_DOTS-1:NUM_CH];
    end else begin
      o_open_sense  <= ~o_open_sense;
      o_short_sense <= ~o_short_sense;
    end
  end
endmodule // lmpsd_matrix

/* File: test/lmpsd_core_props.sv */
// lmpsd_checker: port-level properties of the scan and register core.
// assumes binding onto lmpsd_core, one clock domain.
`timescale 1ns/100ps
module lmpsd_checker
  import lmpsd_pkg::*;
(
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_reset_n,
  input  wire logic                      i_reg_wr,
  input  wire logic                      i_reg_rd,
  input  wire logic [7:0]                i_reg_addr,
  input  wire logic [7:0]                i_reg_wdata,
  input  wire logic [NUM_CH-1:0]         i_open_sense,
  input  wire logic [NUM_CH-1:0]         i_short_sense,
  input  wire logic [7:0]                o_reg_rdata,
  input  wire logic [1:0]                o_row_scan_switch,
  input  wire logic [NUM_CH-1:0]         o_current_sink_channel,
  input  wire logic [NUM_CH*LEVEL_W-1:0] o_sink_level
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_reset_n);
  wire logic is_res = (i_reg_addr >= ADDR_OPEN_BASE && i_reg_addr <= ADDR_OPEN_LAST) ||
                      (i_reg_addr >= ADDR_SHORT_BASE && i_reg_addr <= ADDR_SHORT_LAST);
  sequence s_blank;
    (o_row_scan_switch == 2'b00) [*6];
  endsequence
  sequence s_delay;
    (o_current_sink_channel == {NUM_CH{1'b0}}) [*3];
  endsequence
  rows_exclusive_a: assert property (o_row_scan_switch != 2'b11)
    else $error("both row switches on");
  blank_gap_a: assert property ($fell(|o_row_scan_switch) |-> s_blank)
    else $error("blanking gap too short");
  chan_delay_a: assert property ($rose(|o_row_scan_switch) |-> s_delay)
    else $error("sink on before channel delay");
  sink_in_row_a: assert property (|o_current_sink_channel |-> |o_row_scan_switch)
    else $error("sink on with no row");
  result_top_a: assert property (i_reg_rd && is_res |=> o_reg_rdata[7:6] == 2'b00)
    else $error("result top bits set");
  spread_bits_a: assert property (i_reg_rd && i_reg_addr == ADDR_SPREAD |=>
    (o_reg_rdata & ~SPREAD_MASK) == 8'h00) else $error("spread unused bits set");
  soft_reset_a: assert property (i_reg_wr && i_reg_addr == ADDR_RESET &&
    i_reg_wdata == RESET_CMD |-> ##[1:3] o_sink_level == '0) else $error("levels kept");
  scale_zero_a: assert property (i_reg_wr && i_reg_addr == ADDR_SCALE_BASE &&
    i_reg_wdata == 8'h00 |-> ##[1:3] o_sink_level[LEVEL_W-1:0] == '0) else $error("lvl0");
  rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved without read");
endmodule // lmpsd_checker
bind lmpsd_core lmpsd_checker u_chk (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
  .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_open_sense(i_open_sense), .i_short_sense(i_short_sense),
  .o_reg_rdata(o_reg_rdata), .o_row_scan_switch(o_row_scan_switch),
  .o_current_sink_channel(o_current_sink_channel), .o_sink_level(o_sink_level));

/* File: test/led_matrix_pwm_scan_diag_bench.sv */
// bench: register tasks, detection passes and scan timing of lmpsd_core.
// assumes a short 12-bit scan parameter; inputs move on falling edges.
`timescale 1ns/100ps
module led_matrix_pwm_scan_diag_bench
  import lmpsd_pkg::*;
;
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
  $display("ERROR %0t: got %0h want %0h", $time, a, e); end end
  localparam int P = 400;
  localparam logic [7:0] TA [6] = '{ADDR_CTRL, ADDR_GLOBAL, ADDR_OPEN_BASE,
                                    ADDR_SHORT_LAST, ADDR_SPREAD, ADDR_RESET};
  localparam logic [7:0] TE [6] = '{CTRL_RESET, GLOBAL_RESET, 8'h00, 8'h00,
                                    SPREAD_RESET, 8'h00};
  logic clk = 0, rst_n = 0, wr = 0, rd = 0;
  logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
  logic [1:0] rows;
  logic [NUM_CH-1:0] sinks, osn, ssn;
  logic [NUM_CH*LEVEL_W-1:0] lvl;
  logic [NUM_DOTS-1:0] omap = 24'h84_1021, smap = 24'h12_0C03;
  int num_errors = 0, compares = 0, per, on, sk;
  always #25 clk = ~clk;
  lmpsd_core #(.P_SCAN12_CYCLES(P), .P_SS_CYCLE_CYCLES(2240)) uut (.i_clk_sys(clk),
    .i_reset_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr),
    .i_reg_wdata(wd), .i_open_sense(osn), .i_short_sense(ssn), .o_reg_rdata(rdata),
    .o_row_scan_switch(rows), .o_current_sink_channel(sinks), .o_sink_level(lvl));
  lmpsd_matrix u_led (.i_clk_sys(clk), .i_reset_n(rst_n), .i_rows(rows),
    .i_open_map(omap), .i_short_map(smap), .o_open_sense(osn), .o_short_sense(ssn));
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk); wr = 1; addr = a; wd = d;
    @(negedge clk); wr = 0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(negedge clk); rd = 1; addr = a;
    @(negedge clk); rd = 0;
    @(negedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    rd_reg(a);
    `CHK(rdata, e)
  endtask
  // a pass spans up to three row periods; poll the trigger bit
  task automatic wait_pass(input int b);
    for (int i = 0; i < 80 && (i == 0 || rdata[b] !== 1'b0); i++) begin
      repeat (30) @(negedge clk);
      rd_reg(ADDR_DETECT);
    end
    `CHK(rdata[b], 1'b0)
  endtask
  task automatic wait_row(input logic v);
    for (int i = 0; i < 5000 && rows[0] !== v; i++) @(negedge clk);
  endtask
  // row0 on time, full period and channel 0 on count in that row
  task automatic meas();
    wait_row(1'b0); wait_row(1'b1);
    per = 0; on = 0; sk = 0;
    while (rows[0] === 1'b1 && on < 5000) begin
      on++; sk += int'(sinks[0]); @(negedge clk);
    end
    while (rows[0] === 1'b0 && per < 5000) begin
      per++; @(negedge clk);
    end
    per += on;
  endtask
  task tally_and_finish;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #(60000 * 50);
    num_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1;
    for (int i = 0; i < 6; i++) rd_chk(TA[i], TE[i]);
    wr_reg(ADDR_SPREAD, 8'hFF); rd_chk(ADDR_SPREAD, SPREAD_MASK);
    wr_reg(ADDR_OPEN_BASE, 8'h3F); rd_chk(ADDR_OPEN_BASE, 8'h00);
    wr_reg(ADDR_SPREAD, 8'h00);
    wr_reg(ADDR_GLOBAL, 8'h0F);
    for (int d = 0; d < NUM_DOTS; d++) begin
      wr_reg(ADDR_DUTY_BASE + 8'(2 * d), 8'h80);
      wr_reg(ADDR_DUTY_BASE + 8'(2 * d + 1), 8'hF8);
    end
    rd_chk(ADDR_DUTY_BASE + 8'h01, 8'h08);
    for (int n = 0; n < NUM_CH; n++) wr_reg(ADDR_SCALE_BASE + 8'(n), 8'(n * 21 + 21));
    repeat (3) @(negedge clk);
    for (int n = 0; n < NUM_CH; n++)
      `CHK(lvl[n*LEVEL_W +: LEVEL_W], 16'((n + 1) * 315))
    wr_reg(ADDR_DETECT, 8'h80);
    repeat (3) @(negedge clk);
    for (int n = 0; n < NUM_CH; n++)
      `CHK(lvl[n*LEVEL_W +: LEVEL_W], 16'((n + 1) * 315 / 4))
    wr_reg(ADDR_DETECT, 8'h01); wait_pass(0);
    for (int k = 0; k < 4; k++) rd_chk(ADDR_OPEN_BASE + 8'(k), {2'b00, omap[6*k +: 6]});
    rd_chk(ADDR_SHORT_BASE, 8'h00);
    wr_reg(ADDR_DETECT, 8'h02); wait_pass(1);
    for (int k = 0; k < 4; k++) rd_chk(ADDR_SHORT_BASE + 8'(k), {2'b00, smap[6*k +: 6]});
    rd_chk(ADDR_OPEN_BASE, {2'b00, omap[5:0]});
    wr_reg(ADDR_DETECT, 8'h00); meas(); meas();
    `CHK({per, on}, {2 * P, P - BLANK_CYCLES})
    `CHK(sk > 0, 1'b1)
    wr_reg(ADDR_SPREAD, 8'h10); meas(); meas();
    `CHK(per >= 2 * P - 50 && per <= 2 * P + 50, 1'b1)
    wr_reg(ADDR_SPREAD, 8'h00);
    wr_reg(ADDR_CTRL, 8'h60); wr_reg(ADDR_DUTY_BASE, 8'h00); meas(); meas();
    `CHK({per, on}, {2 * SCAN8_CYCLES, SCAN8_CYCLES - BLANK_CYCLES})
    `CHK(sk, 0)
    wr_reg(ADDR_DUTY_BASE, 8'h04); meas();
    `CHK(sk > 0, 1'b1)
    wr_reg(ADDR_DETECT, 8'h10); meas(); meas();
    `CHK(per, 4 * SCAN8_CYCLES)
    wr_reg(ADDR_SCALE_BASE, 8'h00);
    repeat (3) @(negedge clk);
    `CHK(lvl[LEVEL_W-1:0], 16'h0000)
    wr_reg(ADDR_RESET, 8'h55); rd_chk(ADDR_GLOBAL, 8'h0F);
    wr_reg(ADDR_RESET, RESET_CMD);
    for (int i = 0; i < 6; i++) rd_chk(TA[i], TE[i]);
    meas(); meas();
    `CHK(per, 2 * P)
    wr_reg(ADDR_CTRL, 8'h00);
    meas();
    meas();
    `CHK({per, on}, {P, P - BLANK_CYCLES})
    tally_and_finish();
  end
endmodule // led_matrix_pwm_scan_diag_bench
